// ===== bench/remap_far_model.sv
/* page walker and memory/peer sink standing beside remap_req.
 * assumes the testbench drives the permission, delay and stall knobs. */
`timescale 1ns/1ps
module remap_far_model
	import remap_req_pkg::*;
(
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              xlat_req,
	input  wire logic [ADDR_W-1:0] xlat_addr,
	input  wire logic              slow,
	input  wire logic              perm_r,
	input  wire logic              perm_w,
	input  wire logic              stall,
	output logic                   xlat_ack,
	output logic [ADDR_W-1:0]      xlat_hpa,
	output logic                   xlat_r,
	output logic                   xlat_w,
	output logic                   xlat_fault,
	output logic [3:0]             xlat_fault_code,
	output logic                   sink_ready
);
	// software side: a held entry is never invalidated under traffic
	// reserved ranges would be identity mapped by software; offset map stands
	localparam logic [ADDR_W-1:0] OFS = 48'h0000_4000_0000;
	logic [3:0]        cnt_q;
	logic [1:0]        free_q;
	logic [ADDR_W-1:0] hpa_q;
	// answer lines outside the ack show the inverse, never a stale value
	assign xlat_hpa        = xlat_ack ? hpa_q : ~hpa_q;
	assign xlat_r          = xlat_ack ? perm_r : ~perm_r;
	assign xlat_w          = xlat_ack ? perm_w : ~perm_w;
	assign xlat_fault      = ~xlat_ack;
	assign xlat_fault_code = xlat_ack ? FR_NONE : 4'hf;
	assign sink_ready      = ~stall | (free_q == 2'h0);
	always_ff @(posedge sys_clk) begin
		xlat_ack <= 1'b0;
		free_q   <= free_q + 2'h1;
		if (!rst_n) begin
			hpa_q  <= '0;
			free_q <= 2'h0;
		end
		if (!rst_n || !xlat_req || xlat_ack)
			cnt_q <= 4'h0;
		else if (cnt_q == (slow ? 4'h7 : 4'h1)) begin
			xlat_ack <= 1'b1;
			hpa_q    <= xlat_addr + OFS;
		end else
			cnt_q <= cnt_q + 4'h1;
	end
endmodule : remap_far_model

// ===== bench/testbench.sv
/* self-checking bench for remap_req with a walker and sink model.
 * assumes the walker maps every page by a fixed offset. */
`timescale 1ns/1ps
module testbench
	import remap_req_pkg::*;
;
	localparam logic [ADDR_W-1:0] OFS  = 48'h0000_4000_0000;
	localparam logic [ADDR_W-1:0] PEER = 48'h0000_8000_0000;
	localparam logic [ADDR_W-1:0] RSVD = 48'h0000_c000_0000;
	logic sys_clk, rst_n, remap_enable, platform_screens, peer_fwd_enable;
	logic req_valid, req_write, req_from_link, req_has_ecrc, req_isoch;
	logic slow, perm_r, perm_w, stall, xlat_req, xlat_isoch, xlat_ack;
	logic xlat_r, xlat_w, xlat_fault, sink_ready, mem_valid, peer_valid;
	logic out_be_off, out_write, out_reserved, link_error, fault_valid;
	logic done_valid, cpl_obfuscate, cap_zlr, cap_isoch, gd, gl, gf, lb, lr;
	logic req_ready, lw, gi;
	logic [ADDR_W-1:0]  peer_base, peer_limit, peer_allow_base, peer_allow_limit;
	logic [ADDR_W-1:0]  rsvd_base, rsvd_limit, req_addr, xlat_addr, xlat_hpa;
	logic [ADDR_W-1:0]  out_addr, fault_addr, a, ia[$];
	logic [BYTES_W-1:0] out_bytes, ib[$];
	logic [10:0]        req_len_dw, ln;
	logic [3:0]         req_first_be, xlat_fault_code, fault_reason, fr;
	logic [31:0]        req_hdr, out_ecrc, cpl_data, le;
	logic [2:0]         cpl_status;
	logic               ip[$];
	int                 n_errors, checked;

	remap_req u_remap_req (.*);
	remap_far_model u_remap_far_model (.*);

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task wrap_up;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : wrap_up

	task chk(input string nm, input logic [ADDR_W-1:0] e, input logic [ADDR_W-1:0] g);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	function automatic logic [31:0] crc_of(input logic [79:0] d);
		logic [31:0] c;
		c = CRC_INIT;
		for (int i = 79; i >= 0; i--)
			c = (c << 1) ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h0);
		return ~c;
	endfunction : crc_of

	// one request, then collect issues until done or link error
	task run(input logic [ADDR_W-1:0] ad, input logic [10:0] len, input logic [3:0] be);
		int k;
		ia.delete();
		ib.delete();
		ip.delete();
		{gd, gl, gf} = 3'h0;
		for (k = 0; k < 50 && !req_ready; k++) @(posedge sys_clk) #1;
		if (!req_ready) begin
			n_errors++;
			wrap_up();
		end
		req_addr     = ad;
		req_len_dw   = len;
		req_first_be = be;
		req_valid    = 1'b1;
		@(posedge sys_clk) #1 req_valid = 1'b0;
		for (k = 0; k < 300 && !gd && !gl; k++) begin
			@(posedge sys_clk) #1;
			if (mem_valid || peer_valid) begin
				ia.push_back(out_addr);
				ib.push_back(out_bytes);
				ip.push_back(peer_valid);
				{lb, lr, le} = {out_be_off, out_reserved, out_ecrc};
				lw = out_write;
			end
			if (xlat_req)
				gi = xlat_isoch;
			if (fault_valid) begin
				gf = 1'b1;
				fr = fault_reason;
			end
			gd = done_valid;
			gl = link_error;
		end
		if (!gd && !gl) begin
			n_errors++;
			wrap_up();
		end
	endtask : run

	// pages must come ascending, each cut at the 4KB line
	task split_chk(input logic [ADDR_W-1:0] s, input int tot);
		int i, n;
		for (i = 0; tot > 0; i++) begin
			n = 4096 - int'(s[11:0]);
			if (n > tot)
				n = tot;
			chk("page addr", s + OFS, ia[i]);
			chk("page bytes", n, ib[i]);
			s += n;
			tot -= n;
		end
		chk("page count", i, ia.size());
	endtask : split_chk

	initial begin
		void'($urandom(19981));
		{rst_n, req_valid, req_write, req_from_link, req_has_ecrc, req_isoch} = 6'h0;
		{remap_enable, peer_fwd_enable, perm_r, perm_w} = 4'hf;
		{platform_screens, slow, stall} = 3'h0;
		{req_addr, req_len_dw, req_first_be, req_hdr} = '0;
		peer_base = PEER;
		peer_allow_base = PEER;
		peer_limit = PEER + 48'hffff;
		peer_allow_limit = PEER + 48'hffff;
		rsvd_base = RSVD;
		rsvd_limit = RSVD + 48'hffff;
		repeat (2) @(posedge sys_clk);
		#1 chk("ready in reset", 0, req_ready);
		rst_n = 1'b1;
		@(posedge sys_clk) #1 chk("ready", 1, req_ready);
		chk("cap zlr", 1, cap_zlr);
		chk("cap isoch", 1, cap_isoch);
		for (int t = 0; t < 14; t++) begin
			a = 48'h10_0000 + ($urandom & 48'h3_fffc);
			ln = 11'(1 + $urandom % 1024);
			if (t == 0) {a, ln} = {48'h10_0ffc, 11'd1};
			if (t == 1) {a, ln} = {48'h10_0f00, 11'd1024};
			{req_write, slow, stall, req_isoch} = 4'($urandom);
			run(a, ln, 4'hf);
			split_chk(a, 4 * ln);
			chk("status", CPL_SC, cpl_status);
			chk("write flag", req_write, lw);
			chk("isoch hint", req_isoch, gi);
		end
		{platform_screens, req_from_link, req_write} = 3'h6;
		run(48'h10_0ff0, 11'd8, 4'hf);
		chk("link error", 1, gl);
		chk("screened issues", 0, ia.size());
		{platform_screens, perm_r} = 2'h0;
		run(a, 11'd1, BE_NONE);
		chk("zlr status", CPL_SC, cpl_status);
		chk("zlr fault", 0, gf);
		chk("zlr be off", 1, lb);
		chk("zlr hide", 1, cpl_obfuscate);
		chk("zlr data", OBFUSCATE_PAT, cpl_data);
		run(a, 11'd1, 4'hf);
		chk("read fault", FR_READ_PERM, fr);
		chk("read status", CPL_UR, cpl_status);
		chk("fault addr", a, fault_addr);
		{perm_r, req_has_ecrc, req_write} = 3'h7;
		req_hdr = $urandom;
		run(PEER - OFS + 48'h40, 11'd1, 4'hf);
		chk("peer", 1, ip[0]);
		chk("ecrc", crc_of({req_hdr, PEER + 48'h40}), le);
		run(PEER + 48'h40, 11'd1, 4'hf);
		chk("not peer", 0, ip[0]);
		peer_allow_limit = PEER + 48'h3f;
		run(PEER - OFS + 48'h40, 11'd1, 4'hf);
		chk("deny issues", 0, ia.size());
		chk("deny reason", FR_PEER_DENY, fr);
		run(RSVD - OFS, 11'd1, 4'hf);
		chk("reserved", 1, lr);
		run(RSVD, 11'd1, 4'hf);
		chk("not reserved", 0, lr);
		remap_enable = 1'b0;
		run(a, 11'd1, 4'hf);
		chk("pass through", a, ia[0]);
		wrap_up();
	end
endmodule : testbench

// ===== hw/crc_fold.sv
/*
 * combinational crc32 over one wide word, msb first.
 * assumes the caller registers the result; deep xor tree at wide widths.
 */
`timescale 1ns/1ps
module crc_fold
	import remap_req_pkg::*;
#(
	parameter int DATA_W = 80
) (
	input  wire logic [DATA_W-1:0] data,
	output wire logic [31:0]       crc
);
	logic [31:0] stage [0:DATA_W];

	assign stage[0] = CRC_INIT;
	genvar i;
	generate
		for (i = 0; i < DATA_W; i++) begin : g_bit
			wire fb = stage[i][31] ^ data[DATA_W-1-i];
			assign stage[i+1] = {stage[i][30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
		end
	endgenerate
	assign crc = ~stage[DATA_W];
endmodule : crc_fold

// ===== hw/remap_req.sv
/*
 * dma remap request handler: page split, zero-length reads, peer forwarding,
 * reserved-memory tagging and merged completions.
 * assumes an external page walker answering xlat_req with xlat_ack, and a
 * memory/peer sink that accepts issue pulses when its ready is high.
 */
`timescale 1ns/1ps
module remap_req
	import remap_req_pkg::*;
#(
	parameter bit ZLR_PERMISSIVE = 1'b1,
	parameter bit ISOCH_CAPABLE  = 1'b1
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	input  wire logic              remap_enable,
	input  wire logic              platform_screens,
	input  wire logic              peer_fwd_enable,
	input  wire logic [ADDR_W-1:0] peer_base,
	input  wire logic [ADDR_W-1:0] peer_limit,
	input  wire logic [ADDR_W-1:0] peer_allow_base,
	input  wire logic [ADDR_W-1:0] peer_allow_limit,
	input  wire logic [ADDR_W-1:0] rsvd_base,
	input  wire logic [ADDR_W-1:0] rsvd_limit,
	input  wire logic              req_valid,
	input  wire logic [ADDR_W-1:0] req_addr,
	input  wire logic [10:0]       req_len_dw,
	input  wire logic [3:0]        req_first_be,
	input  wire logic              req_write,
	input  wire logic              req_from_link,
	input  wire logic              req_has_ecrc,
	input  wire logic              req_isoch,
	input  wire logic [31:0]       req_hdr,
	output logic                   req_ready,
	output logic                   xlat_req,
	output logic [ADDR_W-1:0]      xlat_addr,
	output logic                   xlat_isoch,
	input  wire logic              xlat_ack,
	input  wire logic [ADDR_W-1:0] xlat_hpa,
	input  wire logic              xlat_r,
	input  wire logic              xlat_w,
	input  wire logic              xlat_fault,
	input  wire logic [3:0]        xlat_fault_code,
	input  wire logic              sink_ready,
	output logic                   mem_valid,
	output logic                   peer_valid,
	output logic [ADDR_W-1:0]      out_addr,
	output logic [BYTES_W-1:0]     out_bytes,
	output logic                   out_be_off,
	output logic                   out_write,
	output logic                   out_reserved,
	output logic [31:0]            out_ecrc,
	output logic                   link_error,
	output logic                   fault_valid,
	output logic [3:0]             fault_reason,
	output logic [ADDR_W-1:0]      fault_addr,
	output logic                   done_valid,
	output logic [2:0]             cpl_status,
	output logic                   cpl_obfuscate,
	output logic [31:0]            cpl_data,
	output logic                   cap_zlr,
	output logic                   cap_isoch
);
	req_state_e         state_q, state_d;
	logic [ADDR_W-1:0]  cur_q;
	logic [BYTES_W-1:0] remain_q;
	logic               wr_q, zlr_q, link_q, ecrc_q, isoch_q, bad_q, obf_q;
	logic [31:0]        hdr_q;
	logic [ADDR_W-1:0]  hpa_q;
	logic [3:0]         reason_q;

	// request classification
	wire [BYTES_W-1:0] req_bytes  = {req_len_dw[10:0], 2'b00};
	wire               req_zlr    = !req_write && req_len_dw == ZLR_LEN_DW
	                                && req_first_be == BE_NONE;
	wire [ADDR_W-1:0]  req_end    = req_addr + ADDR_W'(req_bytes) - ADDR_W'(1);
	wire               req_cross  = req_addr[ADDR_W-1:PAGE_SHIFT]
	                                != req_end[ADDR_W-1:PAGE_SHIFT];
	wire               screen_hit = req_cross && platform_screens;
	wire               req_take   = state_q == ST_IDLE && req_valid;

	// per-page chunk size for the current sub-request
	wire [BYTES_W-1:0] page_left  = PAGE_BYTES - {1'b0, cur_q[PAGE_SHIFT-1:0]};
	wire [BYTES_W-1:0] chunk      = (remain_q > page_left) ? page_left : remain_q;
	wire               last_chunk = chunk == remain_q;

	// permission outcome, only the walker's view of r/w counts
	wire               r_miss     = !wr_q && !xlat_r;
	wire               w_miss     = wr_q && !xlat_w;
	wire               zlr_wo     = zlr_q && ZLR_PERMISSIVE && xlat_w && !xlat_r;
	wire               perm_bad   = (w_miss || r_miss) && !zlr_wo;
	wire [3:0]         perm_code  = w_miss ? FR_WRITE_PERM : FR_READ_PERM;
	wire               lk_fault   = xlat_fault || perm_bad;
	wire [3:0]         lk_code    = xlat_fault ? xlat_fault_code : perm_code;

	// decode on the translated address only; disabled remap passes through
	wire [ADDR_W-1:0]  eff_hpa    = remap_enable ? xlat_hpa : cur_q;
	wire               is_peer    = hpa_q >= peer_base && hpa_q <= peer_limit;
	wire               peer_ok    = peer_fwd_enable && hpa_q >= peer_allow_base
	                                && hpa_q <= peer_allow_limit;
	wire               is_rsvd    = hpa_q >= rsvd_base && hpa_q <= rsvd_limit;
	wire               sink_go    = state_q == ST_ISSUE && sink_ready;
	wire               peer_deny  = is_peer && !peer_ok;
	wire               lk_done    = state_q == ST_LOOKUP && (xlat_ack || !remap_enable);
	wire [31:0]        new_crc;

	crc_fold #(
		.DATA_W (32 + ADDR_W)
	) u_crc (
		.data (({hdr_q, hpa_q})),
		.crc  (new_crc)
	);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (req_valid)
					state_d = screen_hit ? ST_BLOCK : ST_LOOKUP;
			end
			ST_LOOKUP: begin
				if (lk_done)
					state_d = (remap_enable && lk_fault) ? ST_DONE : ST_ISSUE;
			end
			ST_ISSUE: begin
				if (peer_deny)
					state_d = ST_DONE;
				else if (sink_ready)
					state_d = last_chunk ? ST_DONE : ST_LOOKUP;
			end
			ST_DONE:  state_d = ST_IDLE;
			ST_BLOCK: state_d = ST_IDLE;
			default:  state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n)
			state_q <= ST_IDLE;
		else
			state_q <= state_d;
	end

	// request context; flags held across all sub-requests, address and remainder advance per page
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cur_q    <= '0;
			remain_q <= '0;
			{wr_q, zlr_q, link_q, ecrc_q, isoch_q} <= 5'h00;
			hdr_q    <= 32'h0000_0000;
		end else if (req_take) begin
			cur_q    <= req_addr;
			remain_q <= req_bytes;
			{wr_q, zlr_q, link_q, ecrc_q, isoch_q} <=
				{req_write, req_zlr, req_from_link, req_has_ecrc, req_isoch};
			hdr_q    <= req_hdr;
		end else if (sink_go && !peer_deny) begin
			cur_q    <= cur_q + ADDR_W'(chunk);
			remain_q <= remain_q - chunk;
		end
	end

	// lookup result and merged outcome
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			hpa_q    <= '0;
			bad_q    <= 1'b0;
			obf_q    <= 1'b0;
			reason_q <= FR_NONE;
		end else if (req_take) begin
			bad_q    <= screen_hit;
			obf_q    <= 1'b0;
			reason_q <= FR_NONE;
		end else if (lk_done) begin
			hpa_q <= eff_hpa;
			if (remap_enable && lk_fault) begin
				bad_q    <= 1'b1;
				reason_q <= lk_code;
			end
			if (remap_enable && !lk_fault && zlr_wo)
				obf_q <= 1'b1;
		end else if (state_q == ST_ISSUE && peer_deny) begin
			bad_q    <= 1'b1;
			reason_q <= FR_PEER_DENY;
		end
	end

	// walker port; isochronous hint lets the walker keep the entry
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			xlat_req   <= 1'b0;
			xlat_addr  <= '0;
			xlat_isoch <= 1'b0;
		end else begin
			xlat_req   <= remap_enable && state_d == ST_LOOKUP && !lk_done;
			xlat_addr  <= (state_q == ST_IDLE) ? req_addr : cur_q;
			xlat_isoch <= (state_q == ST_IDLE) ? req_isoch : isoch_q;
		end
	end

	// issue toward memory or a peer target, one pulse per page
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			mem_valid    <= 1'b0;
			peer_valid   <= 1'b0;
			out_addr     <= '0;
			out_bytes    <= '0;
			out_be_off   <= 1'b0;
			out_write    <= 1'b0;
			out_reserved <= 1'b0;
			out_ecrc     <= 32'h0000_0000;
		end else begin
			mem_valid  <= sink_go && !is_peer;
			peer_valid <= sink_go && is_peer && peer_ok;
			if (sink_go) begin
				out_addr     <= hpa_q;
				out_bytes    <= chunk;
				out_be_off   <= zlr_q;
				out_write    <= wr_q;
				out_reserved <= is_rsvd && !is_peer;
				out_ecrc     <= (is_peer && ecrc_q) ? new_crc : 32'h0000_0000;
			end
		end
	end

	// single completion per original request not blocked by screening
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			done_valid    <= 1'b0;
			cpl_status    <= CPL_SC;
			cpl_obfuscate <= 1'b0;
			cpl_data      <= 32'h0000_0000;
			fault_valid   <= 1'b0;
			fault_reason  <= FR_NONE;
			fault_addr    <= '0;
			link_error    <= 1'b0;
		end else begin
			done_valid  <= state_q == ST_DONE;
			fault_valid <= state_q == ST_DONE && bad_q;
			link_error  <= state_q == ST_BLOCK && link_q;
			if (state_q == ST_DONE) begin
				cpl_status    <= bad_q ? CPL_UR : CPL_SC;
				cpl_obfuscate <= obf_q && !bad_q;
				cpl_data      <= (obf_q && !bad_q) ? OBFUSCATE_PAT : 32'h0000_0000;
				fault_reason  <= reason_q;
				fault_addr    <= cur_q;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			req_ready <= 1'b0;
			cap_zlr   <= 1'b0;
			cap_isoch <= 1'b0;
		end else begin
			req_ready <= state_d == ST_IDLE;
			cap_zlr   <= ZLR_PERMISSIVE;
			cap_isoch <= ISOCH_CAPABLE;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_split_in_page: assert property (mem_valid |->
		(out_addr[PAGE_SHIFT-1:0] + out_bytes) <= PAGE_BYTES)
		else $error("issued sub-request crosses a page");
	a_screen_blocks: assert property (req_take && screen_hit |->
		##1 state_q == ST_BLOCK ##1 !mem_valid && !peer_valid)
		else $error("screened crossing request reached remapping");
	a_zlr_be_off: assert property (mem_valid && zlr_q |-> out_be_off)
		else $error("zero-length read issued with byte enables");
	a_zlr_wo_pass: assert property (lk_done && remap_enable && zlr_q && ZLR_PERMISSIVE
		&& !xlat_fault && xlat_w && !xlat_r |-> ##1 state_q == ST_ISSUE)
		else $error("permissive zero-length read faulted");
	a_read_perm_code: assert property (lk_done && remap_enable && !xlat_fault && !wr_q
		&& !xlat_r && !zlr_wo |-> ##2 fault_valid && fault_reason == FR_READ_PERM)
		else $error("read permission fault not reported as 6h");
	a_fault_ur: assert property (fault_valid |-> done_valid && cpl_status == CPL_UR)
		else $error("blocked request not completed as unsupported");
	a_obf_data: assert property (done_valid && cpl_obfuscate |-> cpl_data == OBFUSCATE_PAT
		&& $past(zlr_q, 2))
		else $error("obfuscation on a non zero-length read");
	a_peer_region: assert property (peer_valid |-> peer_fwd_enable
		&& out_addr >= peer_base && out_addr <= peer_limit)
		else $error("peer forward outside translated peer region");
	a_peer_ecrc: assert property (peer_valid && $past(ecrc_q) |-> out_ecrc != 32'h0000_0000
		|| $past(new_crc) == 32'h0000_0000)
		else $error("peer request forwarded without new crc");
endmodule : remap_req

// ===== hw/remap_req_pkg.sv
/*
 * constants, encodings and states shared by the dma remap request handler.
 * assumes byte addresses, 4KB pages and dword-granular request lengths.
 */
// Functional notes
// - unscreened platform: unit splits page-crossing request into one request per 4KB page.
// - screened platform: crossing request blocked before remapping, reported as link error only when from link.
// - one-dword read with all byte enables off is classed zero-length.
// - capability clear: zero-length read translated like any read, faults raised.
// - capability clear: zero-length read to page without read permission is blocked.
// - capability set: zero-length read to write-only page completes without fault.
// - zero-length read to memory is issued with all byte enables off.
// - zero-length read to write-only page returns obfuscated completion data.
// - zero-length permissive capability advertised set by default.
// - remapping enabled: peer request address treated as dma virtual address, translated.
// - peer target decode uses only the translated host physical address.
// - peer forwarding may be limited to a region or disallowed.
// - forwarded peer request with crc gets crc recomputed over translated address.
// - unit exposes whether it handles critical isochronous traffic.
// - isochronous requesters may get prefetch and held translations.
// - reserved memory recognition never uses the untranslated address.
// - read blocked by missing read permission reports fault reason 6h.
// - blocked read from link device completes with unsupported request status; a screen-blocked read gets no completion, only link_error when from link.
package remap_req_pkg;
	localparam int          ADDR_W        = 48;
	localparam int          PAGE_SHIFT    = 12;
	localparam int          BYTES_W       = 13;
	localparam logic [12:0] PAGE_BYTES    = 13'h1000;
	localparam logic [3:0]  BE_NONE       = 4'h0;
	localparam logic [10:0] ZLR_LEN_DW    = 11'h001;
	localparam logic [3:0]  FR_NONE       = 4'h0;
	localparam logic [3:0]  FR_WRITE_PERM = 4'h5;
	localparam logic [3:0]  FR_READ_PERM  = 4'h6;
	localparam logic [3:0]  FR_PEER_DENY  = 4'he;
	localparam logic [2:0]  CPL_SC        = 3'h0;
	localparam logic [2:0]  CPL_UR        = 3'h1;
	localparam logic [31:0] OBFUSCATE_PAT = 32'h5a5a_a5a5;
	localparam logic [31:0] CRC_POLY      = 32'h04c1_1db7;
	localparam logic [31:0] CRC_INIT      = 32'hffff_ffff;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_LOOKUP = 3'b001,
		ST_ISSUE  = 3'b010,
		ST_DONE   = 3'b011,
		ST_BLOCK  = 3'b100
	} req_state_e;
endpackage : remap_req_pkg
